// [hw/gwpc_pkg.sv]
// package: register map, field layout and shared types of the wake polarity block
package gwpc_pkg;
   localparam int          NUM_PINS        = 12;
   localparam logic [11:0] ADDR_WAKE       = 12'h020;
   localparam logic [11:0] ADDR_FUNC_SEL   = 12'h100;
   localparam logic [11:0] ADDR_IRQ_STAT   = 12'h104;
   localparam logic [11:0] ADDR_IRQ_MASK   = 12'h108;
   localparam logic [11:0] ADDR_PIN_STATE  = 12'h10C;
   localparam int          WAKE_EN_LSB     = 0;
   localparam int          WAKE_LVL_LSB    = 16;
   localparam logic [11:0] FIELD_RESET     = 12'h000;
   localparam logic [11:0] FUNC_SEL_RESET  = 12'hFFF;
   localparam logic [31:0] UNMAPPED_READ   = 32'h0000_0000;

   typedef struct packed {
      logic [11:0] wake_level_select;
      logic [11:0] wake_source_enable;
   } gwpc_cfg_t;

   typedef struct packed {
      logic        wr;
      logic        rd;
      logic [11:0] addr;
      logic [31:0] wdata;
   } gwpc_bus_t;

   function automatic logic [31:0] gwpc_pack_wake(input gwpc_cfg_t c);
      logic [31:0] w;
      w                             = 32'h0000_0000;
      w[WAKE_EN_LSB +: NUM_PINS]    = c.wake_source_enable;
      w[WAKE_LVL_LSB +: NUM_PINS]   = c.wake_level_select;
      return w;
   endfunction
endpackage

// [hw/gwpc_sync.sv]
// two-stage synchroniser for the twelve pin levels
`timescale 1ns/100ps
module gwpc_sync (
   input  wire logic        i_clk,
   input  wire logic        i_rst,
   input  wire logic [11:0] i_async,
   output logic      [11:0] o_sync
);
   typedef struct packed {
      logic [11:0] s1;
      logic [11:0] s2;
   } gwpc_sync_st_t;

   gwpc_sync_st_t st_reg;
   gwpc_sync_st_t st_next;

   always_comb begin
      st_next    = st_reg;
      st_next.s1 = i_async;
      st_next.s2 = st_reg.s1;
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign o_sync = st_reg.s2;
endmodule

// [hw/gwpc_trigger.sv]
// per-pin wake qualification: level match, enable and function gating
`timescale 1ns/100ps
module gwpc_trigger (
   input  wire logic [11:0]          i_pin,
   input  wire gwpc_pkg::gwpc_cfg_t  i_cfg,
   input  wire logic [11:0]          i_func_sel,
   output logic      [11:0]          o_trig
);
   // level match: low when select 0, high when select 1 [R1]
   // enabled pins only [R2], alternate-function pins suppressed [R3] [R10]
   assign o_trig = ~(i_pin ^ i_cfg.wake_level_select) & i_cfg.wake_source_enable & ~i_func_sel;
endmodule

// [hw/gwpc_top.sv]
// top: wake enable and polarity register, wake request and interrupt logic
// Functional notes
// R1 - each pin triggers on low level when its polarity bit is 0 and on high level when it is 1.
// R2 - a pin with wake enable 0 never wakes the device, one with enable 1 may.
// R3 - pins assigned to an alternate function never cause a wake event.
// R4 - pin n enable sits at bit n and its polarity at bit 16 plus n.
// R5 - on configuration load both fields take the eeprom bytes, ignoring unused high bits.
// R6 - without eeprom the otp image is used, and an unprogrammed otp gives zero.
// R7 - usb reset or lite soft reset restores the last loaded image, or zero if none.
// R8 - both fields are reset-shielded and ignore resets the shield excludes.
// R9 - software sets a pin as input and sets its wake enable before relying on it.
// R10 - a pin is general purpose when its function select bit is clear.
// R11 - qualified pin triggers are ored into one wake request.
// R12 - reserved bits 31:28 and 15:12 read zero and ignore writes.
`timescale 1ns/100ps
module gwpc_top (
   input  wire logic        i_clk,
   input  wire logic        i_rst,
   input  wire logic [11:0] i_addr,
   input  wire logic [31:0] i_wdata,
   input  wire logic        i_wr,
   input  wire logic        i_rd,
   output logic      [31:0] o_rdata,
   input  wire logic [11:0] i_pin,
   input  wire logic        i_cfg_load,
   input  wire logic        i_eeprom_present,
   input  wire logic [15:0] i_eeprom_wake_en,
   input  wire logic [15:0] i_eeprom_wake_lvl,
   input  wire logic        i_otp_programmed,
   input  wire logic [11:0] i_otp_wake_en,
   input  wire logic [11:0] i_otp_wake_lvl,
   input  wire logic        i_usb_reset,
   input  wire logic        i_lite_soft_reset,
   input  wire logic        i_shield_active,
   output logic             o_wake_req,
   output logic             o_irq
);
   // ========================================================
   // state
   typedef struct packed {
      gwpc_pkg::gwpc_cfg_t cfg;
      gwpc_pkg::gwpc_cfg_t image;
      logic [11:0]         func_sel;
      logic [11:0]         irq_stat;
      logic [11:0]         irq_mask;
      logic [31:0]         rdata;
      logic                wake_req;
      logic                irq;
   } gwpc_st_t;

   gwpc_st_t            st_reg;
   gwpc_st_t            st_next;
   gwpc_pkg::gwpc_bus_t bus;
   logic [11:0]         pin_sync;
   logic [11:0]         trig;
   logic [11:0]         stat_set;
   logic [11:0]         stat_clr;
   gwpc_pkg::gwpc_cfg_t load_img;

   assign bus.wr    = i_wr;
   assign bus.rd    = i_rd;
   assign bus.addr  = i_addr;
   assign bus.wdata = i_wdata;

   // ========================================================
   // pin path
   gwpc_sync u_sync (
      .i_clk   (i_clk),
      .i_rst   (i_rst),
      .i_async (i_pin),
      .o_sync  (pin_sync)
   );

   gwpc_trigger u_trig (
      .i_pin      (pin_sync),
      .i_cfg      (st_reg.cfg),
      .i_func_sel (st_reg.func_sel),
      .o_trig     (trig)
   );

   // ========================================================
   // next state
   always_comb begin
      st_next = st_reg;
      // image select: eeprom low bits, else otp, else zero [R5] [R6]
      if (i_eeprom_present) begin
         load_img.wake_source_enable = i_eeprom_wake_en[11:0];
         load_img.wake_level_select  = i_eeprom_wake_lvl[11:0];
      end else if (i_otp_programmed) begin
         load_img.wake_source_enable = i_otp_wake_en;
         load_img.wake_level_select  = i_otp_wake_lvl;
      end else begin
         load_img.wake_source_enable = gwpc_pkg::FIELD_RESET;
         load_img.wake_level_select  = gwpc_pkg::FIELD_RESET;
      end

      // register writes; reserved bits dropped [R4] [R12]
      if (bus.wr) begin
         if (bus.addr == gwpc_pkg::ADDR_WAKE) begin
            st_next.cfg.wake_source_enable = bus.wdata[gwpc_pkg::WAKE_EN_LSB +: gwpc_pkg::NUM_PINS];
            st_next.cfg.wake_level_select  = bus.wdata[gwpc_pkg::WAKE_LVL_LSB +: gwpc_pkg::NUM_PINS];
         end else if (bus.addr == gwpc_pkg::ADDR_FUNC_SEL) begin
            st_next.func_sel = bus.wdata[11:0];
         end else if (bus.addr == gwpc_pkg::ADDR_IRQ_MASK) begin
            st_next.irq_mask = bus.wdata[11:0];
         end
      end

      // usb or lite reset restores last image, unless shielded [R7] [R8]
      if ((i_usb_reset || i_lite_soft_reset) && !i_shield_active) begin
         st_next.cfg = st_reg.image;
      end
      if (i_cfg_load) begin
         st_next.image = load_img;
         st_next.cfg   = load_img;
      end

      // sticky status, set wins over write-one clear
      stat_set = trig;
      stat_clr = (bus.wr && bus.addr == gwpc_pkg::ADDR_IRQ_STAT) ? bus.wdata[11:0] : 12'h000;
      st_next.irq_stat = (st_reg.irq_stat & ~stat_clr) | stat_set;

      st_next.wake_req = |trig; // [R11]
      st_next.irq      = |(st_next.irq_stat & st_next.irq_mask);

      // read data, valid in the cycle after the strobe
      st_next.rdata = gwpc_pkg::UNMAPPED_READ;
      if (bus.rd) begin
         if (bus.addr == gwpc_pkg::ADDR_WAKE) begin
            st_next.rdata = gwpc_pkg::gwpc_pack_wake(st_reg.cfg); // [R4] [R12]
         end else if (bus.addr == gwpc_pkg::ADDR_FUNC_SEL) begin
            st_next.rdata = {20'h0_0000, st_reg.func_sel};
         end else if (bus.addr == gwpc_pkg::ADDR_IRQ_STAT) begin
            st_next.rdata = {20'h0_0000, st_reg.irq_stat};
         end else if (bus.addr == gwpc_pkg::ADDR_IRQ_MASK) begin
            st_next.rdata = {20'h0_0000, st_reg.irq_mask};
         end else if (bus.addr == gwpc_pkg::ADDR_PIN_STATE) begin
            st_next.rdata = {20'h0_0000, pin_sync};
         end
      end
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         st_reg          <= '0;
         st_reg.func_sel <= gwpc_pkg::FUNC_SEL_RESET;
      end else begin
         st_reg <= st_next;
      end
   end

   assign o_rdata    = st_reg.rdata;
   assign o_wake_req = st_reg.wake_req;
   assign o_irq      = st_reg.irq;
endmodule

// [tb/gwpc_wake_chk.sv]
// checker: wake register read-back, config load and wake request properties
`timescale 1ns/100ps
module gwpc_wake_chk (
   input wire logic        i_clk,
   input wire logic        i_rst,
   input wire logic [11:0] i_addr,
   input wire logic [31:0] i_wdata,
   input wire logic        i_wr,
   input wire logic        i_rd,
   input wire logic [31:0] o_rdata,
   input wire logic [11:0] i_pin,
   input wire logic        i_cfg_load,
   input wire logic        i_eeprom_present,
   input wire logic [15:0] i_eeprom_wake_en,
   input wire logic [15:0] i_eeprom_wake_lvl,
   input wire logic        i_otp_programmed,
   input wire logic        i_usb_reset,
   input wire logic        i_lite_soft_reset,
   input wire logic        o_wake_req,
   input wire logic        o_irq
);
   // ==========
   // properties
   default clocking @(posedge i_clk); endclocking
   default disable iff (i_rst);
   wire calm = !(i_wr || i_cfg_load || i_usb_reset || i_lite_soft_reset);
   wire rdw  = i_rd && i_addr == gwpc_pkg::ADDR_WAKE;
   rd_idle_a: assert property (!$past(i_rd) |-> o_rdata == 32'h0000_0000) else $error("rdata not zero");
   rsv_bits_a: assert property ($past(rdw) |-> (o_rdata & 32'hF000_F000) == 32'h0000_0000)
      else $error("reserved bits set");
   wr_back_a: assert property (i_wr && i_addr == gwpc_pkg::ADDR_WAKE && !i_cfg_load && !i_usb_reset
      && !i_lite_soft_reset ##1 calm ##1 rdw |=> o_rdata == ($past(i_wdata, 3) & 32'h0FFF_0FFF))
      else $error("write not read back");
   ee_load_a: assert property (i_cfg_load && i_eeprom_present ##1 calm ##1 rdw |=>
      o_rdata == ({$past(i_eeprom_wake_lvl, 3), $past(i_eeprom_wake_en, 3)} & 32'h0FFF_0FFF))
      else $error("eeprom image wrong");
   zero_load_a: assert property (i_cfg_load && !i_eeprom_present && !i_otp_programmed ##1 calm ##1 rdw
      |=> o_rdata == 32'h0000_0000) else $error("blank load not zero");
   rst_idle_a: assert property ($fell(i_rst) |-> !o_wake_req && !o_irq) else $error("outputs after reset");
   wake_calm_a: assert property ((calm && $stable(i_pin)) [*4] |=> $stable(o_wake_req))
      else $error("wake moved without cause");
   en_off_a: assert property ($past(rdw) && $past(calm) && o_rdata[11:0] == 12'h000 && calm
      ##1 calm [*3] |=> !o_wake_req)
      else $error("disabled pin woke");
   cover property ($rose(o_wake_req));
   cover property ($rose(o_irq));
   cover property ($fell(o_irq));
endmodule

// [tb/gwpc_bench.sv]
// bench: register, wake qualification and config image scenarios
`timescale 1ns/100ps
module gwpc_bench;
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin failures++; $display("MISMATCH %0t got %h exp %h", $time, a, e); end end
   localparam logic [11:0] wk = gwpc_pkg::ADDR_WAKE;
   logic        i_clk, i_rst, i_wr, i_rd, i_cfg_load, i_usb_reset, i_lite_soft_reset, i_shield_active;
   logic        i_eeprom_present, i_otp_programmed, o_wake_req, o_irq;
   logic [11:0] i_addr, i_pin, i_otp_wake_en, i_otp_wake_lvl;
   logic [15:0] i_eeprom_wake_en, i_eeprom_wake_lvl;
   logic [31:0] i_wdata, o_rdata;
   int          failures, checks;
   gwpc_top dut (.*);
   // ==========
   // bus tasks
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      @(posedge i_clk);
      i_wr    <= 1'h1;
      i_addr  <= a;
      i_wdata <= d;
      @(posedge i_clk);
      i_wr <= 1'h0;
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] e);
      @(posedge i_clk);
      i_rd   <= 1'h1;
      i_addr <= a;
      @(posedge i_clk);
      i_rd <= 1'h0;
      #1 `CHK(o_rdata, e)
   endtask
   task automatic pulse(input logic [2:0] k, input logic [2:0] m);
      @(posedge i_clk);
      {i_shield_active, i_eeprom_present, i_otp_programmed} <= m;
      {i_lite_soft_reset, i_usb_reset, i_cfg_load} <= k;
      @(posedge i_clk);
      {i_lite_soft_reset, i_usb_reset, i_cfg_load} <= 3'h0;
   endtask
   task automatic settle;
      repeat (5) @(posedge i_clk);
      #1;
   endtask
   // ==========
   // scenarios
   task automatic t_regs;
      rd(wk, 32'h0000_0000);
      wr(wk, 32'hFFFF_FFFF);
      rd(wk, 32'h0FFF_0FFF);
      wr(12'h3FC, 32'hFFFF_FFFF);
      rd(12'h3FC, 32'h0000_0000);
      $display("test regs done");
   endtask
   task automatic t_wake;
      wr(gwpc_pkg::ADDR_FUNC_SEL, 32'h0000_0000);
      wr(gwpc_pkg::ADDR_IRQ_MASK, 32'h0000_0FFF);
      for (int l = 0; l < 2; l++) begin
         for (int p = 0; p < 2; p++) begin
            wr(wk, 32'h0000_0020 | (32'(l) << 21));
            @(posedge i_clk);
            i_pin <= 12'(p) << 5;
            settle();
            `CHK(o_wake_req, 1'(p == l))
         end
      end
      `CHK(o_irq, 1'h1)
      wr(wk, 32'h0020_0000);
      rd(wk, 32'h0020_0000);
      settle();
      `CHK(o_wake_req, 1'h0)
      wr(wk, 32'h0020_0020);
      wr(gwpc_pkg::ADDR_FUNC_SEL, 32'h0000_0020);
      settle();
      `CHK(o_wake_req, 1'h0)
      wr(gwpc_pkg::ADDR_IRQ_STAT, 32'h0000_0FFF);
      settle();
      `CHK(o_irq, 1'h0)
      $display("test wake done");
   endtask
   task automatic t_load;
      pulse(3'h1, 3'h3);
      rd(wk, 32'h0456_0123);
      wr(wk, 32'h0000_0000);
      pulse(3'h2, 3'h3);
      rd(wk, 32'h0456_0123);
      wr(wk, 32'h0000_0000);
      pulse(3'h4, 3'h7);
      rd(wk, 32'h0000_0000);
      pulse(3'h1, 3'h1);
      rd(wk, 32'h05A0_00A5);
      pulse(3'h1, 3'h0);
      rd(wk, 32'h0000_0000);
      wr(wk, 32'h0001_0001);
      pulse(3'h4, 3'h0);
      rd(wk, 32'h0000_0000);
      $display("test load done");
   endtask
   task automatic wrap_up;
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   // ==========
   // clock and sequence
   initial begin
      i_clk = 1'h0;
      forever #10 i_clk = ~i_clk;
   end
   initial begin
      {i_rst, i_wr, i_rd, i_cfg_load, i_usb_reset, i_lite_soft_reset, i_shield_active} = 7'h40;
      {i_eeprom_present, i_otp_programmed, i_addr, i_wdata, i_pin} = 58'h3;
      i_eeprom_wake_en  = 16'hF123;
      i_eeprom_wake_lvl = 16'hA456;
      i_otp_wake_en     = 12'h0A5;
      i_otp_wake_lvl    = 12'h5A0;
      repeat (3) @(posedge i_clk);
      i_rst <= 1'h0;
      t_regs();
      t_wake();
      t_load();
      wrap_up();
   end
endmodule
bind gwpc_top gwpc_wake_chk u_chk (.*);
